// ---- shared/rtwd_pkg.sv ----
// constants for the reset-hold timer and watchdog block
// assumes a 250 MHz system clock that never stops, even in sleep
package rtwd_pkg;
	// clock rate and documented periods
	localparam int CLK_MHZ          = 250;
	localparam int HOLD_LONG_MS     = 18;
	localparam int HOLD_SHORT_NS    = 10000;
	localparam int WDOG_BASE_MS     = 18;
	localparam int HOLD_LONG_CYC    = HOLD_LONG_MS * 1000 * CLK_MHZ;
	localparam int HOLD_SHORT_CYC   = HOLD_SHORT_NS * CLK_MHZ / 1000;
	localparam int WDOG_BASE_CYC    = WDOG_BASE_MS * 1000 * CLK_MHZ;
	localparam int PRESC_MAX_RATIO  = 128;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam logic [7:0] IDX_OPTION = 8'h04;
	localparam logic [7:0] IDX_EVENTS = 8'h05;
	localparam logic [7:0] IDX_MASK   = 8'h06;

	// status register field positions
	localparam int ST_WAKE_BIT  = 7;
	localparam int ST_TMOUT_BIT = 4;
	localparam int ST_PWRDN_BIT = 3;

	// option register fields: assign bit and ratio exponent
	localparam int OPT_ASSIGN_BIT = 3;
	localparam int OPT_RATIO_MSB  = 2;
	localparam logic [3:0] OPT_RESET = 4'h0;

	// event bits, shared by event status and mask registers
	localparam int EV_WDOG = 0;
	localparam int EV_REL  = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_W    = 3;

	// oscillator configuration codes
	typedef enum logic [2:0] {
		OSC_INTRC,
		OSC_EXT_RC,
		OSC_FAST_XTAL,
		OSC_STD_XTAL,
		OSC_LOW_XTAL,
		OSC_EXT_CLK
	} rtwd_osc_t;
endpackage

// ---- verilog/rtwd_core.sv ----
// reset-hold timer and watchdog with wishbone register access
// assumes the core reports clear and sleep instructions as one-cycle
// pulses and stops its own clock while sleep_o is high
//
// Register access over Wishbone was chosen for this implementation.

// Behaviour
// RQ1: core held in reset while hold timer runs
// RQ2: hold timer has its own free-running timebase
// RQ3: long hold after power-on, mode-dependent afterwards
// RQ4: hold counted from external reset going high
// RQ5: watchdog timeout in sleep restarts hold timer
// RQ6: four reset sources: power, pin, watchdog, wake
// RQ7: watchdog timebase keeps running during sleep
// RQ8: watchdog timeout resets device, awake or asleep
// RQ9: watchdog reset clears the timeout flag
// RQ10: enable config low disables watchdog entirely
// RQ11: unscaled watchdog period is the base period
// RQ12: software assigns prescaler up to one in 128
// RQ13: clear instruction zeroes watchdog and its prescaler
// RQ14: sleep instruction zeroes watchdog and its prescaler
// RQ15: status flags tell the reset cause apart
// RQ16: flags follow power-up, clear and sleep
// RQ17: flags after each reset match the cause
// RQ18: flags hold until reset, pin pulse keeps them
// RQ19: period is base times ratio when assigned
module rtwd_core
	import rtwd_pkg::*;
#(
	parameter int HOLD_LONG  = HOLD_LONG_CYC,
	parameter int HOLD_SHORT = HOLD_SHORT_CYC,
	parameter int WDOG_BASE  = WDOG_BASE_CYC,
	parameter int CNT_W      = 23
)
(
	// clock and power-on reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// configuration and pins
	input  wire logic [2:0]  osc_mode_i,
	input  wire logic        watchdog_enable_config_i,
	input  wire logic        external_reset_n_i,
	input  wire logic        pin_change_i,
	// core instruction events
	input  wire logic        watchdog_clear_instr_i,
	input  wire logic        sleep_instr_i,
	// outputs to core and system
	output logic             core_reset_o,
	output logic             sleep_o,
	output logic             irq_o
);
	if (CNT_W < 2 || CNT_W > 30)
		$error("counter width out of range");
	if (HOLD_LONG < 1 || HOLD_SHORT < 1 || WDOG_BASE < 1)
		$error("periods must be at least one cycle");
	if (HOLD_LONG >= (1 << CNT_W) || HOLD_SHORT >= (1 << CNT_W) ||
	    WDOG_BASE >= (1 << CNT_W))
		$error("period does not fit counter width");

	typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} rtwd_state_t;

	rtwd_state_t        st;
	rtwd_state_t        next_st;
	logic [CNT_W-1:0]   hold_cnt;
	logic [CNT_W-1:0]   next_hold;
	logic [CNT_W-1:0]   wd_cnt;
	logic [6:0]         presc_cnt;
	logic [3:0]         option;
	logic               timeout_flag_n;
	logic               powerdown_flag_n;
	logic               pin_change_wake_flag;
	logic [EV_W-1:0]    ev_stat;
	logic [EV_W-1:0]    ev_mask;
	logic [EV_W-1:0]    ev_set;
	logic               wdog_expire;
	logic               wdog_zero;
	logic               wake_pin;
	logic               hold_done;
	logic               bus_req;
	logic               bus_wr;
	logic [7:0]         status_rd;

	// ratio exponent to terminal prescaler count, 1:1 up to 1:128
	function automatic logic [6:0] presc_last(input logic [2:0] e);
		logic [7:0] r;
		r = 8'h01 << e;
		return 7'(r - 8'h01);
	endfunction

	// subsequent hold length; crystal modes need the long wait
	function automatic logic [CNT_W-1:0] hold_len(input logic [2:0] m);
		logic [CNT_W-1:0] v;
		v = CNT_W'(HOLD_SHORT - 1);
		if (m == OSC_FAST_XTAL || m == OSC_STD_XTAL ||
		    m == OSC_LOW_XTAL)
			v = CNT_W'(HOLD_LONG - 1);
		return v;
	endfunction

	// watchdog events; the timebase is clk_i, which sleep never stops
	assign wdog_zero   = watchdog_clear_instr_i || sleep_instr_i ||
	                     st == ST_HOLD;
	assign wdog_expire = watchdog_enable_config_i && st != ST_HOLD &&
	                     !wdog_zero && wd_cnt == CNT_W'(WDOG_BASE - 1) &&
	                     (!option[OPT_ASSIGN_BIT] ||
	                      presc_cnt == presc_last(option[OPT_RATIO_MSB:0]));
	assign wake_pin    = st == ST_SLEEP && pin_change_i;
	assign hold_done   = st == ST_HOLD && external_reset_n_i &&
	                     hold_cnt == '0;

	// next state; pin reset beats watchdog beats wake-up
	always_comb
	begin
		next_st = st;
		next_hold = hold_cnt;
		if (!external_reset_n_i)
		begin
			next_st = ST_HOLD; // [RQ4] [RQ6]
			next_hold = hold_len(osc_mode_i);
		end
		else if (wdog_expire || wake_pin)
		begin
			next_st = ST_HOLD; // [RQ5] [RQ8] [RQ6]
			next_hold = hold_len(osc_mode_i);
		end
		else
		begin
			case (st)
				ST_HOLD:
				begin
					if (hold_cnt == '0)
						next_st = ST_RUN;
					else
						next_hold = hold_cnt - 1'b1; // [RQ1]
				end
				ST_RUN:
				begin
					if (sleep_instr_i)
						next_st = ST_SLEEP;
				end
				ST_SLEEP:
					next_st = ST_SLEEP;
				default:
					next_st = ST_HOLD;
			endcase
		end
	end

	// state and hold counter; power-on always loads the long hold
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st <= ST_HOLD;
			hold_cnt <= CNT_W'(HOLD_LONG - 1); // [RQ3] [RQ2]
		end
		else
		begin
			st <= next_st;
			hold_cnt <= next_hold; // [RQ3]
		end
	end

	// outputs straight from flops, mirroring the next state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_reset_o <= 1'b1;
			sleep_o <= 1'b0;
		end
		else
		begin
			core_reset_o <= next_st == ST_HOLD; // [RQ1]
			sleep_o <= next_st == ST_SLEEP;
		end
	end

	// watchdog base counter and prescaler, own timebase
	always_ff @(posedge clk_i)
	begin
		if (rst_i || wdog_zero || !watchdog_enable_config_i)
		begin
			wd_cnt <= '0; // [RQ13] [RQ14] [RQ10]
			presc_cnt <= '0;
		end
		else if (wd_cnt == CNT_W'(WDOG_BASE - 1))
		begin
			wd_cnt <= '0; // [RQ11] [RQ7]
			if (option[OPT_ASSIGN_BIT])
				presc_cnt <= presc_cnt + 1'b1; // [RQ19] [RQ12]
		end
		else
			wd_cnt <= wd_cnt + 1'b1;
	end

	// cause flags; each cause writes its own pattern, others hold
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timeout_flag_n <= 1'b1; // [RQ16] [RQ17]
			powerdown_flag_n <= 1'b1;
			pin_change_wake_flag <= 1'b0;
		end
		else if (!external_reset_n_i)
			pin_change_wake_flag <= 1'b0; // [RQ17] [RQ18]
		else if (wdog_expire)
		begin
			timeout_flag_n <= 1'b0; // [RQ9]
			if (st == ST_SLEEP)
				powerdown_flag_n <= 1'b0; // [RQ17]
			pin_change_wake_flag <= 1'b0;
		end
		else if (wake_pin)
		begin
			timeout_flag_n <= 1'b1; // [RQ17]
			powerdown_flag_n <= 1'b0;
			pin_change_wake_flag <= 1'b1;
		end
		else if (st == ST_RUN && sleep_instr_i)
		begin
			timeout_flag_n <= 1'b1; // [RQ16]
			powerdown_flag_n <= 1'b0;
		end
		else if (st == ST_RUN && watchdog_clear_instr_i)
		begin
			timeout_flag_n <= 1'b1; // [RQ16]
			powerdown_flag_n <= 1'b1;
		end
	end

	// wishbone decode; ack one cycle after the request is seen
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_wr  = bus_req && we_i && sel_i[0];

	// status image; unused bits read as zero
	always_comb
	begin
		status_rd = '0;
		status_rd[ST_WAKE_BIT] = pin_change_wake_flag;
		status_rd[ST_TMOUT_BIT] = timeout_flag_n; // [RQ15]
		status_rd[ST_PWRDN_BIT] = powerdown_flag_n;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= bus_req;
			dat_o <= '0; // unmapped reads answer zero
			if (bus_req && !we_i)
			begin
				case (adr_i[7:2])
					IDX_STATUS[5:0]: dat_o <= {24'h000000, status_rd};
					IDX_OPTION[5:0]: dat_o <= {28'h0000000, option};
					IDX_EVENTS[5:0]: dat_o <= {29'h00000000, ev_stat};
					IDX_MASK[5:0]:   dat_o <= {29'h00000000, ev_mask};
					default:         dat_o <= '0;
				endcase
			end
		end
	end

	// option register: prescaler assign and ratio exponent
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			option <= OPT_RESET;
		else if (bus_wr && adr_i[7:2] == IDX_OPTION[5:0])
			option <= dat_i[3:0]; // [RQ12]
	end

	// interrupt mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ev_mask <= '0;
		else if (bus_wr && adr_i[7:2] == IDX_MASK[5:0])
			ev_mask <= dat_i[EV_W-1:0];
	end

	// sticky events, write one to clear; a new event wins the clear
	always_comb
	begin
		ev_set = '0;
		ev_set[EV_WDOG] = wdog_expire;
		ev_set[EV_REL] = hold_done;
		ev_set[EV_WAKE] = wake_pin && external_reset_n_i && !wdog_expire;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ev_stat <= '0;
		else if (bus_wr && adr_i[7:2] == IDX_EVENTS[5:0])
			ev_stat <= (ev_stat & ~dat_i[EV_W-1:0]) | ev_set;
		else
			ev_stat <= ev_stat | ev_set;
	end

	// level interrupt from any unmasked event
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(next_ev() & ev_mask);
	end

	// event status as it will be after this edge
	function automatic logic [EV_W-1:0] next_ev();
		logic [EV_W-1:0] v;
		v = ev_stat | ev_set;
		if (bus_wr && adr_i[7:2] == IDX_EVENTS[5:0])
			v = (ev_stat & ~dat_i[EV_W-1:0]) | ev_set;
		return v;
	endfunction

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence pin_wakes;
		st == ST_SLEEP && pin_change_i && external_reset_n_i &&
		!wdog_expire;
	endsequence

	sequence held_in_reset;
		st == ST_HOLD && core_reset_o;
	endsequence

	hold_reset_a: assert property ( // [RQ1]
		st == ST_HOLD && $past(st) == ST_HOLD |-> core_reset_o)
		else $error("core not held while hold timer runs");

	por_flags_a: assert property ( // [RQ16]
		$past(rst_i) |-> timeout_flag_n && powerdown_flag_n &&
		!pin_change_wake_flag && hold_cnt == CNT_W'(HOLD_LONG - 1))
		else $error("power-up flags or hold length wrong");

	ext_hold_a: assert property ( // [RQ4]
		!external_reset_n_i |=> held_in_reset ##0
		hold_cnt == hold_len($past(osc_mode_i)))
		else $error("pin reset did not reload hold timer");

	hold_count_a: assert property ( // [RQ3]
		st == ST_HOLD && hold_cnt != '0 && external_reset_n_i &&
		!wdog_expire |=> hold_cnt == $past(hold_cnt) - 1'b1)
		else $error("hold timer did not count down");

	wdog_reset_a: assert property ( // [RQ9]
		wdog_expire && external_reset_n_i |=> !timeout_flag_n ##0
		held_in_reset)
		else $error("watchdog timeout did not reset and flag");

	wdog_off_a: assert property ( // [RQ10]
		!watchdog_enable_config_i |-> !wdog_expire && wd_cnt == '0 ||
		$past(watchdog_enable_config_i))
		else $error("disabled watchdog still counting");

	sleep_clear_a: assert property ( // [RQ14]
		sleep_instr_i |=> wd_cnt == '0 && presc_cnt == '0)
		else $error("sleep did not zero watchdog");

	clear_flags_a: assert property ( // [RQ16]
		st == ST_RUN && watchdog_clear_instr_i && !sleep_instr_i &&
		external_reset_n_i |=> timeout_flag_n && powerdown_flag_n)
		else $error("clear instruction flags wrong");

	pin_wake_a: assert property ( // [RQ17]
		pin_wakes |=> pin_change_wake_flag && timeout_flag_n &&
		!powerdown_flag_n ##0 held_in_reset)
		else $error("pin-change wake flags wrong");

	sleep_wdog_a: assert property ( // [RQ5]
		st == ST_SLEEP && wdog_expire && external_reset_n_i |=>
		held_in_reset ##0 !powerdown_flag_n ##1 st == ST_HOLD)
		else $error("sleep timeout did not restart hold timer");
endmodule

// ---- sim/rtwd_core_model.sv ----
// processor core stand-in: issues clear and sleep instructions
// assumes the block stops the core while reset or sleep is high
module rtwd_core_model
(
	// clock and block state
	input  wire logic       clk_i,
	input  wire logic       core_reset_i,
	input  wire logic       sleep_i,
	// keep-alive interval in cycles, zero for never
	input  wire logic [7:0] clear_every_i,
	// instruction pulses to the block
	output logic            clear_o,
	output logic            sleep_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	logic       pclr = 1'b0;
	logic       tclr = 1'b0;
	logic       tslp = 1'b0;
	assign clear_o = pclr | tclr;
	assign sleep_o = tslp;
	// periodic keep-alive; a stopped core executes nothing
	always @(posedge clk_i)
	begin
		pclr <= 1'b0;
		if (core_reset_i || sleep_i || clear_every_i == 8'h00)
			cnt <= 8'h00;
		else if (cnt + 8'h01 >= clear_every_i)
		begin
			cnt <= 8'h00;
			pclr <= 1'b1;
		end
		else
			cnt <= cnt + 8'h01;
	end
	// one instruction, only once the core runs again
	task automatic exec(input bit slp);
		while (core_reset_i !== 1'b0 || sleep_i !== 1'b0)
			@(posedge clk_i);
		tslp <= slp;
		tclr <= !slp;
		@(posedge clk_i);
		tslp <= 1'b0;
		tclr <= 1'b0;
	endtask
endmodule

// ---- sim/tb.sv ----
// bench for the reset-hold timer and watchdog
// assumes short hold and watchdog counts set by parameter
module tb
	import rtwd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HL = 40;
	localparam int HSH = 10;
	localparam int WB = 20;
	localparam logic [7:0] A_ST = IDX_STATUS << 2;
	localparam logic [7:0] A_OP = IDX_OPTION << 2;
	localparam logic [7:0] A_EV = IDX_EVENTS << 2;
	localparam logic [7:0] A_MK = IDX_MASK << 2;
	logic        clk_i, rst_i, cyc, stb, we, ext_n, pin, watchdog_enable_config, m;
	logic        ack_o, clr, slp, core_reset_o, sleep_o, irq_o;
	logic [7:0]  adr, every;
	logic [3:0]  sel;
	logic [2:0]  osc;
	logic [31:0] dat, rd, dat_o;
	int          miscompares, check_count, n;
	int          cyc_n = 0;
	int          rat[3] = '{1, 2, 128};
	logic [7:0]  opt[3] = '{8'h00, 8'h09, 8'h0f};
	// free-running system clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	rtwd_core #(.HOLD_LONG(HL), .HOLD_SHORT(HSH), .WDOG_BASE(WB))
		rtwd_core_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.osc_mode_i(osc), .watchdog_enable_config_i(watchdog_enable_config),
		.external_reset_n_i(ext_n), .pin_change_i(pin),
		.watchdog_clear_instr_i(clr), .sleep_instr_i(slp),
		.core_reset_o(core_reset_o), .sleep_o(sleep_o), .irq_o(irq_o));
	rtwd_core_model rtwd_core_model_i (.clk_i(clk_i),
		.core_reset_i(core_reset_o), .sleep_i(sleep_o),
		.clear_every_i(every), .clear_o(clr), .sleep_o(slp));
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rng(input string nm, input int v, lo, hi);
		chk(nm, {31'h0, v >= lo && v <= hi}, 32'h1);
	endtask
	// single classic cycle; waits for ack, with no limit but the bench timeout
	task automatic wb(input logic w, input logic [7:0] a, input int d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic hold(output int c);
		c = 0;
		while (core_reset_o !== 1'b0)
		begin
			@(posedge clk_i);
			c++;
		end
	endtask
	// pin reset pulse in a given oscillator mode, then the hold length
	task automatic ext_hold(input logic [2:0] md, output int c);
		osc <= md;
		ext_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		ext_n <= 1'b1;
		hold(c);
	endtask
	task automatic til(output int c);
		c = 0;
		while (core_reset_o !== 1'b1)
		begin
			@(posedge clk_i);
			c++;
		end
	endtask
	function automatic logic [31:0] st(input logic w, t, p);
		st = 32'h0;
		st[ST_WAKE_BIT] = w;
		st[ST_TMOUT_BIT] = t;
		st[ST_PWRDN_BIT] = p;
	endfunction
	task automatic stop_test;
		$display("TB: %0d checks %0d errors", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard, well above the few thousand cycles needed
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 20000)
		begin
			miscompares++;
			stop_test;
		end
	end
	// main sequence
	initial
	begin
		{rst_i, cyc, stb, we, watchdog_enable_config, ext_n, pin} = 7'b1000010;
		adr = 8'h00;
		sel = 4'h1;
		dat = 32'h0;
		osc = OSC_INTRC;
		every = 8'h00;
		miscompares = 0;
		check_count = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		hold(n);
		rng("por hold", n, HL, HL + 3);
		wb(1, A_ST, 32'hff);
		wb(0, A_ST, 0);
		chk("status por", rd, st(0, 1, 1));
		wb(0, 8'h3c, 0);
		chk("unmapped", rd, 0);
		// irq must differ between all-masked and none-masked
		wb(1, A_MK, 7);
		repeat (2) @(posedge clk_i);
		m = irq_o;
		wb(1, A_MK, 0);
		repeat (2) @(posedge clk_i);
		chk("irq mask", {31'h0, m ^ irq_o}, 1);
		chk("irq set", {31'h0, m}, 1);
		wb(1, A_EV, 7);
		wb(0, A_EV, 0);
		chk("events clear", rd, 0);
		repeat (3 * WB) @(posedge clk_i);
		wb(0, A_ST, 0);
		chk("wdog off", rd, st(0, 1, 1));
		watchdog_enable_config <= 1'b1;
		every <= 8'(WB / 2);
		repeat (5 * WB) @(posedge clk_i);
		wb(0, A_ST, 0);
		chk("kept alive", rd, st(0, 1, 1));
		every <= 8'h00;
		foreach (opt[i])
		begin
			wb(1, A_OP, opt[i]);
			rtwd_core_model_i.exec(0);
			til(n);
			rng("wdog period", n, WB * rat[i] - 1, WB * rat[i] + 3);
			hold(n);
			rng("short hold", n, HSH, HSH + 3);
			wb(0, A_ST, 0);
			chk("status wdog", rd, st(0, 0, 1));
		end
		osc <= OSC_STD_XTAL;
		wb(1, A_OP, 0);
		rtwd_core_model_i.exec(1);
		@(posedge clk_i);
		chk("sleep out", {31'h0, sleep_o}, 1);
		til(n);
		chk("sleep end", {31'h0, sleep_o}, 0);
		rng("sleep wdog", n, WB - 1, WB + 3);
		hold(n);
		rng("wake hold", n, HL, HL + 3);
		watchdog_enable_config <= 1'b0;
		wb(0, A_ST, 0);
		chk("status wdog wake", rd, st(0, 0, 0));
		wb(0, A_EV, 0);
		chk("events wdog", rd, 32'(1 << EV_WDOG | 1 << EV_REL));
		wb(1, A_EV, 7);
		osc <= OSC_INTRC;
		pin <= 1'b1;
		repeat (4) @(posedge clk_i);
		pin <= 1'b0;
		wb(0, A_ST, 0);
		chk("pin awake", rd, st(0, 0, 0));
		rtwd_core_model_i.exec(1);
		pin <= 1'b1;
		til(n);
		pin <= 1'b0;
		hold(n);
		rng("pin wake hold", n, HSH, HSH + 3);
		wb(0, A_ST, 0);
		chk("status pin wake", rd, st(1, 1, 0));
		wb(0, A_EV, 0);
		chk("events pin", rd, 32'(1 << EV_WAKE | 1 << EV_REL));
		osc <= OSC_FAST_XTAL;
		ext_n <= 1'b0;
		repeat (60) @(posedge clk_i);
		chk("ext reset", {31'h0, core_reset_o}, 1);
		ext_n <= 1'b1;
		hold(n);
		rng("ext hold", n, HL, HL + 3);
		wb(0, A_ST, 0);
		chk("status ext", rd, st(0, 1, 0));
		ext_hold(OSC_LOW_XTAL, n);
		rng("low xtal hold", n, HL, HL + 3);
		ext_hold(OSC_EXT_RC, n);
		rng("ext rc hold", n, HSH, HSH + 3);
		ext_hold(OSC_EXT_CLK, n);
		rng("ext clk hold", n, HSH, HSH + 3);
		stop_test;
	end
endmodule
